// ---- rtl/smsg_pkg.sv ----
// shared constants and types for the secure messaging session block
package smsg_pkg;

  localparam int            BYTE_W     = 8;
  localparam int            BLK_W      = 128;
  localparam int            BLK_BYTES  = 16;
  localparam int            MSG_W      = 256;
  localparam int            CTR_W      = 16;
  localparam int            TI_W       = 32;
  localparam int            CAP_BYTES  = 6;
  localparam int            CAP_W      = 48;
  localparam int            MACT_W     = 64;
  localparam int            RND_W      = 160;

  localparam logic [15:0]   CTR_CLR    = 16'h0000;
  localparam logic [15:0]   CTR_MAX    = 16'hFFFF;
  localparam logic [15:0]   CTR_STEP   = 16'h0001;
  localparam logic [15:0]   LBL_CMD    = 16'hA55A;
  localparam logic [15:0]   LBL_RSP    = 16'h5AA5;
  localparam logic [63:0]   IV_TAIL    = 64'h0000000000000000;
  localparam logic [7:0]    PAD_MARK   = 8'h80;
  localparam logic [159:0]  RNG_SEED   = 160'h0000000000000000000000000000000000000001;

  // bit positions inside the iv input block
  localparam int            IVB_LBL_HI = 127;
  localparam int            IVB_CTR_HI = 79;

  localparam logic [5:0]    LEN_NONE   = 6'h00;
  localparam logic [5:0]    LEN_ONE    = 6'h10;
  localparam logic [5:0]    LEN_TWO    = 6'h20;

  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_FIRST_P1    = 3'b001,
    OP_FOLLOWUP_P1 = 3'b010,
    OP_PART2       = 3'b011,
    OP_SECURED     = 3'b100
  } smsg_op_t;

  typedef enum logic [2:0] {
    RC_OK        = 3'b000,
    RC_MORE      = 3'b001,
    RC_INTEGRITY = 3'b010,
    RC_AUTH_ERR  = 3'b011,
    RC_NO_KEY    = 3'b100,
    RC_PERM      = 3'b101
  } smsg_rc_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_P1_ENC = 3'b001,
    ST_P2_D0  = 3'b010,
    ST_P2_D1  = 3'b011,
    ST_P2_E0  = 3'b100,
    ST_P2_E1  = 3'b101,
    ST_IV_ENC = 3'b110
  } smsg_state_t;

endpackage

// ---- rtl/smsg_rng.sv ----
// free running pseudo random source for challenges and identifiers
`timescale 1ns/1ns
`default_nettype none
module smsg_rng
  import smsg_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  output logic [RND_W-1:0]      rnd
);

  logic [RND_W-1:0] lfsr_q;

  // stand-in for a true entropy source; swap for a trng in silicon
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lfsr_q <= RNG_SEED;
    end else begin
      lfsr_q <= {lfsr_q[RND_W-2:0],
                 lfsr_q[RND_W-1] ^ lfsr_q[RND_W-2] ^ lfsr_q[RND_W-19] ^ lfsr_q[RND_W-20]};
    end
  end

  assign rnd = lfsr_q;

endmodule
`default_nettype wire

// ---- rtl/smsg_session.sv ----
// card side aes secure messaging session controller
// Functional notes
// - fresh random 4-byte identifier, used in macs
// - 16-bit counter cleared on first auth, kept
// - counter serialised least significant byte first
// - card checks mac, increments before responding
// - command uses old count, response new count
// - counter at FFFFh treated as mac failure when cmd_keeps_auth is set
// - chained frames count as one command
// - cmac truncated to even-numbered output bytes
// - data ciphered with aes-128 cbc, session key
// - pad 80h then zeros, never in auth
// - iv is ecb of label, identifier, counter, zeros
// - handshake encryption uses all-zero iv
// - part one: check key, challenge, clear, identifier
// - non part-two command aborts pending handshake
// - longer reader messages accepted if length ok
// - verify rotated challenge, answer with caps echo
// - reader capabilities cut or zero-extended to six
// - success authenticates; failure or origin key does not
// - followup auth needs active session unless origin
// - followup keeps identifier and counter, no caps
// - bad mac: integrity_fail_code, no mac, drop auth
// - mac inputs carry counter then identifier
`timescale 1ns/1ns
`default_nettype none
module smsg_session
  import smsg_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire smsg_op_t           cmd_op,
  input  wire logic               cmd_key_exists,
  input  wire logic               cmd_key_origin,
  input  wire logic               cmd_length_capability_field_ok,
  input  wire logic               cmd_mac_ok,
  input  wire logic               cmd_keeps_auth,
  input  wire logic               cmd_last,
  input  wire logic [MSG_W-1:0]   cmd_data,
  input  wire logic [CAP_W-1:0]   reader_capability_field,
  input  wire logic [3:0]         reader_cap_len,
  input  wire logic [CAP_W-1:0]   card_capability_field,
  output logic                    rsp_valid,
  output smsg_rc_t                rsp_rc,
  output logic [MSG_W-1:0]        rsp_data,
  output logic [5:0]              rsp_len,
  input  wire logic               iv_req,
  input  wire logic               iv_for_rsp,
  output logic                    iv_ready,
  output logic                    iv_valid,
  output logic [BLK_W-1:0]        iv_out,
  output logic                    cph_start,
  output logic                    cph_decrypt,
  output logic                    cph_session_key,
  output logic [BLK_W-1:0]        cph_blk_in,
  input  wire logic               cph_done,
  input  wire logic [BLK_W-1:0]   cph_dout,
  input  wire logic [BLK_W-1:0]   mac_full_in,
  output logic [MACT_W-1:0]       mac_trunc,
  input  wire logic [BLK_W-1:0]   pad_in,
  input  wire logic [4:0]         pad_cnt,
  output logic [BLK_W-1:0]        pad_out,
  output logic [CTR_W+TI_W-1:0]   mac_ctr_ti,
  output logic                    authenticated,
  output logic                    auth_pending,
  output logic [CTR_W-1:0]        command_counter,
  output logic [TI_W-1:0]         transaction_identifier
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [BLK_W-1:0] rotl(input logic [BLK_W-1:0] x);
    return {x[BLK_W-BYTE_W-1:0], x[BLK_W-1 -: BYTE_W]};
  endfunction

  function automatic logic [CAP_W-1:0] cap_fit(input logic [CAP_W-1:0] c, input logic [3:0] n);
    logic [CAP_W-1:0] r;
    r = '0;
    for (int i = 0; i < CAP_BYTES; i++) begin
      if (i < int'(n)) begin
        r[CAP_W-1-BYTE_W*i -: BYTE_W] = c[CAP_W-1-BYTE_W*i -: BYTE_W];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  smsg_state_t        state_q;
  logic               cph_wait_q;
  logic               auth_q;
  logic               pend_q;
  logic               pend_first_q;
  logic               pend_origin_q;
  logic [CTR_W-1:0]   ctr_q;
  logic [TI_W-1:0]    ti_q;
  logic [BLK_W-1:0]   chal_q;
  logic [BLK_W-1:0]   rdr_q;
  logic [MSG_W-1:0]   msg_q;
  logic [CAP_W-1:0]   rcap_q;
  logic [BLK_W-1:0]   blk_q;
  logic               rsp_valid_q;
  smsg_rc_t           rsp_rc_q;
  logic [MSG_W-1:0]   rsp_data_q;
  logic [5:0]         rsp_len_q;
  logic               iv_valid_q;
  logic [BLK_W-1:0]   iv_q;
  logic [MACT_W-1:0]  mac_trunc_q;
  logic [BLK_W-1:0]   pad_q;
  logic [RND_W-1:0]   rnd;

  smsg_rng u_rng (
    .mclk (mclk),
    .nrst (nrst),
    .rnd  (rnd)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic take, done, first_ok, nf_ok, p2_ok, sec_last, sec_bad, sec_ok, chal_match;
  logic hs_fail, abort, finish, ev_deauth, ev_auth_set, iv_take;

  assign take       = cmd_valid && (state_q == ST_IDLE);
  assign done       = cph_done && cph_wait_q;
  assign first_ok   = take && (cmd_op == OP_FIRST_P1) && cmd_key_exists && cmd_length_capability_field_ok;
  assign nf_ok      = take && (cmd_op == OP_FOLLOWUP_P1) && cmd_key_exists
                      && (auth_q || cmd_key_origin);
  assign p2_ok      = take && (cmd_op == OP_PART2) && pend_q && cmd_length_capability_field_ok;
  assign sec_last   = take && (cmd_op == OP_SECURED) && cmd_last;
  assign sec_bad    = sec_last && (!auth_q || !cmd_mac_ok
                      || ((ctr_q == CTR_MAX) && cmd_keeps_auth));
  assign sec_ok     = sec_last && !sec_bad;
  assign chal_match = ((cph_dout ^ msg_q[MSG_W-1 -: BLK_W]) == rotl(chal_q));
  assign abort      = take && pend_q && (cmd_op != OP_PART2);
  assign hs_fail    = (take && (((cmd_op == OP_FIRST_P1) && !first_ok)
                      || ((cmd_op == OP_FOLLOWUP_P1) && !nf_ok)
                      || ((cmd_op == OP_PART2) && !p2_ok)))
                      || ((state_q == ST_P2_D1) && done && !chal_match);
  assign finish     = done && (((state_q == ST_P2_E0) && !pend_first_q) || (state_q == ST_P2_E1));
  assign ev_auth_set = finish && !pend_origin_q;
  assign ev_deauth  = hs_fail || abort || sec_bad || first_ok || (finish && pend_origin_q);
  assign iv_take    = iv_req && (state_q == ST_IDLE) && !cmd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // command counter: cleared by nrst and by first auth only, one step per good complete command
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctr_q <= CTR_CLR;
    end else if (first_ok) begin
      ctr_q <= CTR_CLR;
    end else if (sec_ok) begin
      ctr_q <= ctr_q + CTR_STEP;
    end
  end

  // identifier and challenge drawn together so both come from one rng state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ti_q   <= '0;
      chal_q <= '0;
      rcap_q <= '0;
    end else if (first_ok) begin
      ti_q   <= rnd[RND_W-1 -: TI_W];
      chal_q <= rnd[BLK_W-1:0];
      rcap_q <= cap_fit(reader_capability_field, reader_cap_len);
    end else if (nf_ok) begin
      chal_q <= rnd[BLK_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      auth_q <= 1'b0;
    end else if (ev_auth_set) begin
      auth_q <= 1'b1;
    end else if (ev_deauth) begin
      auth_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cph_wait_q <= 1'b0;
    end else if (cph_start) begin
      cph_wait_q <= 1'b1;
    end else if (cph_done) begin
      cph_wait_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake sequencer; all handshake blocks chain from a zero iv
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q       <= ST_IDLE;
      pend_q        <= 1'b0;
      pend_first_q  <= 1'b0;
      pend_origin_q <= 1'b0;
      blk_q         <= '0;
      rdr_q         <= '0;
      msg_q         <= '0;
      rsp_valid_q   <= 1'b0;
      rsp_rc_q      <= RC_OK;
      rsp_data_q    <= '0;
      rsp_len_q     <= LEN_NONE;
      iv_valid_q    <= 1'b0;
      iv_q          <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      iv_valid_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            if (abort) begin
              pend_q <= 1'b0;
            end
            rsp_data_q <= '0;
            rsp_len_q  <= LEN_NONE;
            case (cmd_op)
              OP_FIRST_P1, OP_FOLLOWUP_P1: begin
                if (first_ok || nf_ok) begin
                  pend_first_q  <= (cmd_op == OP_FIRST_P1);
                  pend_origin_q <= cmd_key_origin;
                  blk_q         <= rnd[BLK_W-1:0];
                  state_q       <= ST_P1_ENC;
                end else begin
                  rsp_valid_q <= 1'b1;
                  rsp_rc_q    <= cmd_key_exists ? RC_AUTH_ERR : RC_NO_KEY;
                end
              end
              OP_PART2: begin
                if (p2_ok) begin
                  msg_q   <= cmd_data;
                  blk_q   <= cmd_data[MSG_W-1 -: BLK_W];
                  state_q <= ST_P2_D0;
                end else begin
                  pend_q      <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  rsp_rc_q    <= RC_AUTH_ERR;
                end
              end
              OP_SECURED: begin
                rsp_valid_q <= 1'b1;
                if (!cmd_last) begin
                  rsp_rc_q <= RC_MORE;
                end else if (!auth_q) begin
                  rsp_rc_q <= RC_PERM;
                end else begin
                  rsp_rc_q <= sec_bad ? RC_INTEGRITY : RC_OK;
                end
              end
              default: begin
                rsp_valid_q <= 1'b1;
                rsp_rc_q    <= RC_PERM;
              end
            endcase
          end else if (iv_take) begin
            blk_q   <= {(iv_for_rsp ? LBL_RSP : LBL_CMD), ti_q, ctr_q[7:0], ctr_q[15:8], IV_TAIL};
            state_q <= ST_IV_ENC;
          end
        end
        ST_P1_ENC: begin
          if (done) begin
            rsp_valid_q <= 1'b1;
            rsp_rc_q    <= RC_MORE;
            rsp_data_q  <= {cph_dout, {BLK_W{1'b0}}};
            rsp_len_q   <= LEN_ONE;
            pend_q      <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_P2_D0: begin
          if (done) begin
            rdr_q   <= cph_dout;
            blk_q   <= msg_q[BLK_W-1:0];
            state_q <= ST_P2_D1;
          end
        end
        ST_P2_D1: begin
          if (done) begin
            if (chal_match) begin
              blk_q   <= rotl(rdr_q);
              state_q <= ST_P2_E0;
            end else begin
              pend_q      <= 1'b0;
              rsp_valid_q <= 1'b1;
              rsp_rc_q    <= RC_AUTH_ERR;
              state_q     <= ST_IDLE;
            end
          end
        end
        ST_P2_E0: begin
          if (done) begin
            rsp_data_q[MSG_W-1 -: BLK_W] <= cph_dout;
            if (pend_first_q) begin
              blk_q   <= {ti_q, card_capability_field, rcap_q} ^ cph_dout;
              state_q <= ST_P2_E1;
            end else begin
              pend_q      <= 1'b0;
              rsp_valid_q <= 1'b1;
              rsp_rc_q    <= RC_OK;
              rsp_len_q   <= LEN_ONE;
              state_q     <= ST_IDLE;
            end
          end
        end
        ST_P2_E1: begin
          if (done) begin
            rsp_data_q[BLK_W-1:0] <= cph_dout;
            pend_q      <= 1'b0;
            rsp_valid_q <= 1'b1;
            rsp_rc_q    <= RC_OK;
            rsp_len_q   <= LEN_TWO;
            state_q     <= ST_IDLE;
          end
        end
        ST_IV_ENC: begin
          if (done) begin
            iv_q       <= cph_dout;
            iv_valid_q <= 1'b1;
            state_q    <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mac truncation and padding helpers for the outer mac and cbc datapath
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mac_trunc_q <= '0;
    end else begin
      for (int i = 0; i < MACT_W / BYTE_W; i++) begin
        mac_trunc_q[MACT_W-1-BYTE_W*i -: BYTE_W] <= mac_full_in[BLK_W-1-2*BYTE_W*i -: BYTE_W];
      end
    end
  end

  // pad_cnt of 16 means an aligned tail: the caller then sends a full extra block
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pad_q <= '0;
    end else begin
      for (int i = 0; i < BLK_BYTES; i++) begin
        if (i < int'(pad_cnt)) begin
          pad_q[BLK_W-1-BYTE_W*i -: BYTE_W] <= pad_in[BLK_W-1-BYTE_W*i -: BYTE_W];
        end else if (i == int'(pad_cnt)) begin
          pad_q[BLK_W-1-BYTE_W*i -: BYTE_W] <= PAD_MARK;
        end else begin
          pad_q[BLK_W-1-BYTE_W*i -: BYTE_W] <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_ready       = (state_q == ST_IDLE);
  assign iv_ready        = (state_q == ST_IDLE) && !cmd_valid;
  assign cph_start       = (state_q != ST_IDLE) && !cph_wait_q;
  assign cph_decrypt     = (state_q == ST_P2_D0) || (state_q == ST_P2_D1);
  assign cph_session_key = (state_q == ST_IV_ENC);
  assign cph_blk_in      = blk_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_rc          = rsp_rc_q;
  assign rsp_data        = rsp_data_q;
  assign rsp_len         = rsp_len_q;
  assign iv_valid        = iv_valid_q;
  assign iv_out          = iv_q;
  assign mac_trunc       = mac_trunc_q;
  assign pad_out         = pad_q;
  assign mac_ctr_ti      = {ctr_q[7:0], ctr_q[15:8], ti_q};
  assign authenticated   = auth_q;
  assign auth_pending    = pend_q;
  assign command_counter = ctr_q;
  assign transaction_identifier = ti_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_CTR_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
    first_ok |=> (ctr_q == CTR_CLR) && (ti_q == $past(rnd[RND_W-1 -: TI_W])))
    else $error("counter not cleared on first auth");
  AST_CTR_INC: assert property (@(posedge mclk) disable iff (!nrst)
    sec_ok |=> (ctr_q == $past(ctr_q) + CTR_STEP) && rsp_valid && (rsp_rc == RC_OK))
    else $error("counter not stepped on good command");
  AST_CHAIN_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (take && (cmd_op == OP_SECURED) && !cmd_last) |=> $stable(ctr_q) && (rsp_rc == RC_MORE))
    else $error("chained frame moved counter");
  AST_MAX_REJ: assert property (@(posedge mclk) disable iff (!nrst)
    (sec_last && auth_q && (ctr_q == CTR_MAX) && cmd_keeps_auth)
      |=> !auth_q && (rsp_rc == RC_INTEGRITY) && (ctr_q == CTR_MAX))
    else $error("counter at max not rejected");
  AST_MAC_FAIL: assert property (@(posedge mclk) disable iff (!nrst)
    (sec_last && auth_q && !cmd_mac_ok) |=> !auth_q && rsp_valid && (rsp_len == LEN_NONE))
    else $error("bad mac kept session");
  AST_ABORT: assert property (@(posedge mclk) disable iff (!nrst)
    abort |=> !pend_q ##1 !authenticated)
    else $error("pending handshake not aborted");
  AST_NF_REJ: assert property (@(posedge mclk) disable iff (!nrst)
    (take && (cmd_op == OP_FOLLOWUP_P1) && !auth_q && !cmd_key_origin)
      |=> rsp_valid && (rsp_rc != RC_MORE) && (state_q == ST_IDLE))
    else $error("followup accepted while unauthenticated");
  AST_IV_FMT: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == ST_IV_ENC) |-> (cph_blk_in[IVB_CTR_HI -: BYTE_W] == ctr_q[7:0])
      && (cph_session_key && !cph_decrypt))
    else $error("iv block malformed");
  AST_ORIGIN: assert property (@(posedge mclk) disable iff (!nrst)
    (finish && pend_origin_q) |=> !auth_q && (rsp_rc == RC_OK))
    else $error("origin key left session active");
  AST_TRUNC: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 1'b1 |-> (mac_trunc[MACT_W-1 -: BYTE_W] == $past(mac_full_in[BLK_W-1 -: BYTE_W])))
    else $error("mac truncation wrong byte");

endmodule
`default_nettype wire

// ---- verif/smsg_cph_model.sv ----
// cipher engine stand-in: xor with a fixed key so decryption undoes encryption
`timescale 1ns/1ns
`default_nettype none
module smsg_cph_model
  import smsg_pkg::*;
#(
  parameter logic [BLK_W-1:0] KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
)(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             slow,
  input  wire logic             cph_start,
  input  wire logic [BLK_W-1:0] cph_blk_in,
  output logic                  cph_done,
  output logic [BLK_W-1:0]      cph_dout
);
  logic [3:0]       cnt_q;
  logic [BLK_W-1:0] res_q;
  // result only valid with done; otherwise the bus toggles so stale data cannot pass
  always @(posedge mclk) begin
    cph_done <= 1'b0;
    cph_dout <= ~cph_dout;
    if (!nrst) begin
      cnt_q    <= 4'h0;
      cph_dout <= '0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        cph_done <= 1'b1;
        cph_dout <= res_q;
      end
    end else if (cph_start) begin
      res_q <= cph_blk_in ^ KEY;
      cnt_q <= slow ? 4'h6 : 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/smsg_session_bench.sv ----
// self-checking bench for the secure messaging session controller
`timescale 1ns/1ns
`default_nettype none
module smsg_session_bench
  import smsg_pkg::*;
;
  localparam logic [BLK_W-1:0] KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  localparam logic [BLK_W-1:0] RA  = 128'h1122334455667788990011223344AA55;
  localparam logic [BLK_W-1:0] PAT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [CAP_W-1:0] RC6 = 48'hA8BBCCDDEEFF;
  localparam logic [CAP_W-1:0] CC6 = 48'h010203040506;
  logic             mclk, nrst, cmd_valid, cmd_ready, key_ex, key_org, length_capability_field, mac_ok;
  logic             keeps, last, rsp_valid, iv_req, iv_rsp, iv_ready, iv_valid, slow;
  logic             cph_start, cph_dec, cph_sk, cph_done, authd, pend;
  smsg_op_t         op;
  smsg_rc_t         rsp_rc;
  logic [MSG_W-1:0] cmd_data, rsp_data;
  logic [CAP_W-1:0] rcap, ccap;
  logic [3:0]       rcap_len;
  logic [5:0]       rsp_len;
  logic [4:0]       pad_cnt;
  logic [BLK_W-1:0] iv_out, blk_in, dout, mac_in, pad_in, pad_out;
  logic [63:0]      mac_trunc;
  logic [47:0]      mac_ctr_ti;
  logic [15:0]      ctr, ectr;
  logic [31:0]      ti, tid;
  int               bad_count, check_count;

  smsg_session DUT (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(op), .cmd_key_exists(key_ex), .cmd_key_origin(key_org), .cmd_length_capability_field_ok(length_capability_field),
    .cmd_mac_ok(mac_ok), .cmd_keeps_auth(keeps), .cmd_last(last), .cmd_data(cmd_data),
    .reader_capability_field(rcap), .reader_cap_len(rcap_len), .card_capability_field(ccap),
    .rsp_valid(rsp_valid), .rsp_rc(rsp_rc), .rsp_data(rsp_data), .rsp_len(rsp_len),
    .iv_req(iv_req), .iv_for_rsp(iv_rsp), .iv_ready(iv_ready), .iv_valid(iv_valid),
    .iv_out(iv_out), .cph_start(cph_start), .cph_decrypt(cph_dec), .cph_session_key(cph_sk),
    .cph_blk_in(blk_in), .cph_done(cph_done), .cph_dout(dout), .mac_full_in(mac_in),
    .mac_trunc(mac_trunc), .pad_in(pad_in), .pad_cnt(pad_cnt), .pad_out(pad_out),
    .mac_ctr_ti(mac_ctr_ti), .authenticated(authd), .auth_pending(pend),
    .command_counter(ctr), .transaction_identifier(ti));

  smsg_cph_model #(.KEY(KEY)) ENG (.mclk(mclk), .nrst(nrst), .slow(slow), .cph_start(cph_start),
    .cph_blk_in(blk_in), .cph_done(cph_done), .cph_dout(dout));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [MSG_W-1:0] exp, input logic [MSG_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rc(input smsg_rc_t exp);
    check_count++;
    if (rsp_rc !== exp) begin
      bad_count++;
      $display("mismatch rsp_rc expected %0d seen %0d", exp, rsp_rc);
    end
  endtask

  // bounded wait for a response or iv pulse, sampled mid-cycle
  task automatic await(input logic iv);
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      if ((iv ? iv_valid : rsp_valid) === 1'b1)
        return;
    end
    bad_count++;
    $display("mismatch wait expected pulse seen none");
    complete_run();
  endtask

  task automatic send(input smsg_op_t o, input logic l, input logic m);
    @(posedge mclk);
    op        <= o;
    last      <= l;
    mac_ok    <= m;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    await(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // two-part handshake played as the reader would
  task automatic auth(input logic first);
    logic [BLK_W-1:0] rb, c0, r0, d;
    send(first ? OP_FIRST_P1 : OP_FOLLOWUP_P1, 1'b1, 1'b1);
    chk_rc(RC_MORE);
    chk("p1_len", LEN_ONE, rsp_len);
    chk("pend", 1'b1, pend);
    if (first)
      chk("ctr_clr", CTR_CLR, ctr);
    rb = rsp_data[255:128] ^ KEY;
    c0 = RA ^ KEY;
    @(posedge mclk);
    cmd_data <= {c0, {rb[119:0], rb[127:120]} ^ c0 ^ KEY};
    send(OP_PART2, 1'b1, 1'b1);
    chk_rc(RC_OK);
    r0 = {RA[119:0], RA[127:120]} ^ KEY;
    chk("rsp0", r0, rsp_data[255:128]);
    if (first) begin
      // the reader learns the identifier only from the decrypted answer
      d   = rsp_data[127:0] ^ KEY ^ r0;
      tid = d[127:96];
      chk("caps", {CC6, ((rcap_len == 4'h3) ? {RC6[47:24], 24'h000000} : RC6)}, d[95:0]);
      chk("ti_out", tid, ti);
      chk("len2", LEN_TWO, rsp_len);
    end else
      chk("len_f", LEN_ONE, rsp_len);
    chk("authd", !key_org, authd);
  endtask

  task automatic iv_chk(input logic r);
    @(posedge mclk);
    iv_req <= 1'b1;
    iv_rsp <= r;
    @(posedge mclk);
    iv_req <= 1'b0;
    await(1'b1);
    chk("iv", {r ? LBL_RSP : LBL_CMD, tid, ectr[7:0], ectr[15:8], IV_TAIL} ^ KEY, iv_out);
  endtask

  task automatic helpers(input logic [4:0] n, input logic [BLK_W-1:0] ep, input logic [MACT_W-1:0] et);
    @(posedge mclk);
    pad_cnt <= n;
    mac_in  <= ep;
    @(posedge mclk);
    @(negedge mclk);
    chk("pad", ep, pad_out);
    chk("mac_trunc", et, mac_trunc);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    {nrst, cmd_valid, key_org, mac_ok, last, iv_req, iv_rsp, slow} = '0;
    {key_ex, length_capability_field, keeps} = 3'b111;
    op = OP_NONE;
    {cmd_data, rcap, ccap, rcap_len, pad_cnt} = '0;
    {mac_in, pad_in} = {PAT, PAT};
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge mclk);
    nrst     <= 1'b1;
    rcap     <= RC6;
    ccap     <= CC6;
    rcap_len <= 4'h3;
    key_ex   <= 1'b0;
    @(negedge mclk);
    chk("rst", 1'b0, {authd, ctr, ti});
    send(OP_FIRST_P1, 1'b1, 1'b1);
    chk_rc(RC_NO_KEY);
    @(posedge mclk);
    key_ex <= 1'b1;
    send(OP_FOLLOWUP_P1, 1'b1, 1'b1);
    chk_rc(RC_AUTH_ERR);
    @(posedge mclk);
    slow <= 1'b1;
    auth(1'b1);
    ectr = CTR_CLR;
    @(posedge mclk);
    slow <= 1'b0;
    send(OP_SECURED, 1'b0, 1'b1);
    chk_rc(RC_MORE);
    chk("ctr_chain", ectr, ctr);
    send(OP_SECURED, 1'b1, 1'b1);
    ectr = ectr + CTR_STEP;
    chk_rc(RC_OK);
    chk("ctr_inc", ectr, ctr);
    chk("mac_ctr_ti", {ectr[7:0], ectr[15:8], tid}, mac_ctr_ti);
    iv_chk(1'b0);
    iv_chk(1'b1);
    auth(1'b0);
    chk("ti_keep", tid, ti);
    chk("ctr_keep", ectr, ctr);
    helpers(5'h05, 128'h00112233448000000000000000000000, 64'h0022440000000000);
    helpers(5'h10, PAT, 64'h0022446688AACCEE);
    helpers(5'h00, 128'h80000000000000000000000000000000, 64'h8000000000000000);
    send(OP_SECURED, 1'b1, 1'b0);
    chk_rc(RC_INTEGRITY);
    chk("len0", LEN_NONE, rsp_len);
    chk("drop", 1'b0, authd);
    @(posedge mclk);
    key_org <= 1'b1;
    auth(1'b0);
    @(posedge mclk);
    length_capability_field <= 1'b0;
    send(OP_FOLLOWUP_P1, 1'b1, 1'b1);
    chk_rc(RC_MORE);
    send(OP_PART2, 1'b1, 1'b1);
    chk_rc(RC_AUTH_ERR);
    chk("fail_auth", 1'b0, authd);
    @(posedge mclk);
    key_org  <= 1'b0;
    length_capability_field   <= 1'b1;
    rcap_len <= 4'h9;
    auth(1'b1);
    send(OP_FIRST_P1, 1'b1, 1'b1);
    send(OP_SECURED, 1'b1, 1'b1);
    chk_rc(RC_PERM);
    chk("abort", 1'b0, {pend, authd});
    complete_run();
  end
endmodule
`default_nettype wire
